// >>> dv/ssa_arbiter_tb.sv
// self-checking bench for the shared sram port arbiter
`timescale 1ns/1ps
module ssa_arbiter_tb;
   logic        i_clk = 1'b0, i_reset = 1'b1, boff = 1'b0, c_want = 1'b0, b_want = 1'b0;
   logic        c_req, c_we, c_gnt, c_done, b_req, b_we, b_gnt, b_done, bk_en, sc, sb, rr, rb, cw, bw;
   logic [14:0] c_addr, b_addr;
   logic [31:0] c_wd, b_wd, c_rd, b_rd, cd, bd, lfsr = 32'h0000_774a;
   logic [47:0] c_op = '0, b_op = '0;
   int          error_cnt = 0, comparisons = 0, cyc = 0, mode = 0, ca, ba;
   bit          own_cpu;
   // stimulus keeps word addresses below eight so reads meet written words
   logic [31:0] mem [8];
   logic [7:0]  mem_ok = 8'h00;
   always #2.5 i_clk = ~i_clk;
   ssa_arbiter uut (.i_clk(i_clk), .i_reset(i_reset), .i_cpu_req(c_req), .i_cpu_we(c_we),
      .i_cpu_addr(c_addr), .i_cpu_wdata(c_wd), .o_cpu_gnt(c_gnt), .o_cpu_done(c_done),
      .o_cpu_rdata(c_rd), .i_bus_req(b_req), .i_bus_we(b_we), .i_bus_addr(b_addr),
      .i_bus_wdata(b_wd), .o_bus_gnt(b_gnt), .o_bus_done(b_done), .o_bus_rdata(b_rd),
      .i_backup_retain_off(boff), .o_backup_supply_pin_sram_en(bk_en));
   ssa_req_model cpu_m (.i_clk(i_clk), .i_reset(i_reset), .i_want(c_want), .i_op(c_op),
      .i_done(c_done), .o_req(c_req), .o_we(c_we), .o_addr(c_addr), .o_wdata(c_wd));
   ssa_req_model bus_m (.i_clk(i_clk), .i_reset(i_reset), .i_want(b_want), .i_op(b_op),
      .i_done(b_done), .o_req(b_req), .o_we(b_we), .o_addr(b_addr), .o_wdata(b_wd));
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // modes: cpu alone, bus alone, steady contention, random mix
   always @(posedge i_clk) begin
      lfsr = lfsr_next(lfsr);
      c_want <= #1 mode == 0 || mode == 2 || (mode == 3 && lfsr[0]);
      b_want <= #1 mode == 1 || mode == 2 || (mode == 3 && lfsr[1]);
      c_op <= #1 {lfsr[2], 12'h000, lfsr[5:3], lfsr};
      b_op <= #1 {lfsr[6], 12'h000, lfsr[9:7], ~lfsr};
      boff <= #1 lfsr[10];
   end
   // reference: who is served at this edge, then compare once outputs settle
   always @(posedge i_clk) begin
      rr = i_reset;
      rb = boff;
      sc = !rr && c_req && (!b_req || !own_cpu);
      sb = !rr && b_req && (!c_req || own_cpu);
      {cw, ca, cd, bw, ba, bd} = {c_we, 17'h0_0000, c_addr, c_wd, b_we, 17'h0_0000, b_addr, b_wd};
      #2;
      own_cpu = rr || sc || (own_cpu && !sb);
      chk(c_done, sc);
      chk(b_done, sb);
      chk({c_gnt, b_gnt}, {own_cpu, !own_cpu});
      chk(bk_en, rr || !rb);
      if (sc) begin
         if (cw) begin
            mem[ca] = cd;
            mem_ok[ca] = 1'b1;
         end else if (mem_ok[ca]) chk(c_rd, mem[ca]);
      end
      if (sb) begin
         if (bw) begin
            mem[ba] = bd;
            mem_ok[ba] = 1'b1;
         end else if (mem_ok[ba]) chk(b_rd, mem[ba]);
      end
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         test_done;
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_reset <= #1 1'b0;
      for (int m = 0; m < 4; m++) begin
         mode <= #1 m;
         repeat (200) @(posedge i_clk);
         $display("test %0d done, errors %0d", m, error_cnt);
      end
      // second reset in mid traffic must park on the cpu again
      i_reset <= #1 1'b1;
      repeat (3) @(posedge i_clk);
      i_reset <= #1 1'b0;
      repeat (50) @(posedge i_clk);
      $display("test reset done, errors %0d", error_cnt);
      test_done;
   end
endmodule

// >>> dv/ssa_req_model.sv
// requester model for one arbiter port
`timescale 1ns/1ps
module ssa_req_model (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_want,
   input  wire logic [47:0] i_op,
   input  wire logic        i_done,
   output logic             o_req,
   output logic             o_we,
   output logic [14:0]      o_addr,
   output logic [31:0]      o_wdata
);
   initial {o_req, o_we, o_addr, o_wdata} = '0;
   // a refused request stays up unchanged; idle lines keep changing
   always @(posedge i_clk) begin
      if (i_reset || !o_req || i_done) begin
         o_req <= #1 i_want && !i_reset;
         {o_we, o_addr, o_wdata} <= #1 i_op;
      end
   end
endmodule

// >>> logic/ssa_arbiter.sv
// two-port arbiter in front of the shared word-wide sram
// Notes on behaviour
// [R1] memory is 32-bit words, 64 or 96 Kbytes by variant
// [R2] cpu data coupled port access completes in one cycle when granted; here a granted cpu request waits one cycle when the bus also requests
// [R3] a lone requester is served with no wait states
// [R4] simultaneous requests alternate grant, one word each, no starvation
// [R5] when idle the grant stays parked on the most recent user
// [R6] instruction fetches over the bus see no waits without cpu contention
// [R7] dma enters through the bus port under the same arbitration
// [R8] firmware control disables backup supply switchover to the memory
// [R9] after reset the grant parks on the cpu data coupled port
`timescale 1ns/1ps
`include "ssa_cfg.svh"
module ssa_arbiter import ssa_pkg::*; #(
   parameter int SIZE_KB = `SSA_SIZE_LARGE_KB,
   parameter int WORD_W  = `SSA_WORD_W,
   parameter int DEPTH   = SIZE_KB * `SSA_BYTES_PER_KB / `SSA_BYTES_PER_WD,
   parameter int ADDR_W  = $clog2(DEPTH)
) (
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_cpu_req,
   input  wire logic              i_cpu_we,
   input  wire logic [ADDR_W-1:0] i_cpu_addr,
   input  wire logic [WORD_W-1:0] i_cpu_wdata,
   output logic                   o_cpu_gnt,
   output logic                   o_cpu_done,
   output logic      [WORD_W-1:0] o_cpu_rdata,
   input  wire logic              i_bus_req,
   input  wire logic              i_bus_we,
   input  wire logic [ADDR_W-1:0] i_bus_addr,
   input  wire logic [WORD_W-1:0] i_bus_wdata,
   output logic                   o_bus_gnt,
   output logic                   o_bus_done,
   output logic      [WORD_W-1:0] o_bus_rdata,
   input  wire logic              i_backup_retain_off,
   output logic                   o_backup_supply_pin_sram_en
);
   ssa_owner_t        owner_ff;
   ssa_owner_t        nxt_owner;
   logic              serve_cpu;
   logic              serve_bus;
   logic              done_cpu_ff;
   logic              done_bus_ff;
   logic              mem_en;
   logic              mem_we;
   logic [ADDR_W-1:0] mem_addr;
   logic [WORD_W-1:0] mem_wdata;
   logic [WORD_W-1:0] mem_rdata;

   // sizes other than the two variants are refused at elaboration
   if (SIZE_KB != `SSA_SIZE_SMALL_KB && SIZE_KB != `SSA_SIZE_LARGE_KB) begin : g_size_chk // R1
      $error("unsupported sram size");
   end

   // a port wins alone, or under contention when it does not hold the memory
   function automatic logic ssa_port_wins(
      input logic own_req,
      input logic other_req,
      input logic is_owner
   );
      return own_req && (!other_req || !is_owner);
   endfunction

   // contention alternates; a lone requester always wins at once
   always_comb begin
      serve_cpu = ssa_port_wins(i_cpu_req, i_bus_req, owner_ff == SSA_OWN_CPU); // R2 R3 R4
      serve_bus = ssa_port_wins(i_bus_req, i_cpu_req, owner_ff == SSA_OWN_BUS); // R3 R4 R6 R7
   end

   always_comb begin
      nxt_owner = owner_ff; // R5
      if (serve_cpu) begin
         nxt_owner = SSA_OWN_CPU;
      end else if (serve_bus) begin
         nxt_owner = SSA_OWN_BUS;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         owner_ff <= SSA_OWN_CPU; // R9
      end else begin
         owner_ff <= nxt_owner;
      end
   end

   // grant outputs mirror the parked owner so an idle port sees its standing grant
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_cpu_gnt <= 1'b1; // R9
         o_bus_gnt <= 1'b0;
      end else begin
         o_cpu_gnt <= (nxt_owner == SSA_OWN_CPU); // R5
         o_bus_gnt <= (nxt_owner == SSA_OWN_BUS);
      end
   end

   assign mem_en    = serve_cpu | serve_bus;
   assign mem_we    = serve_cpu ? i_cpu_we : i_bus_we;
   assign mem_addr  = serve_cpu ? i_cpu_addr : i_bus_addr;
   assign mem_wdata = serve_cpu ? i_cpu_wdata : i_bus_wdata;

   ssa_sram #(
      .WORD_W (WORD_W),
      .DEPTH  (DEPTH),
      .ADDR_W (ADDR_W)
   ) u_sram (
      .i_clk   (i_clk),
      .i_en    (mem_en),
      .i_we    (mem_we),
      .i_addr  (mem_addr),
      .i_wdata (mem_wdata),
      .o_rdata (mem_rdata)
   );

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         done_cpu_ff <= 1'b0;
         done_bus_ff <= 1'b0;
      end else begin
         done_cpu_ff <= serve_cpu; // R2
         done_bus_ff <= serve_bus;
      end
   end

   assign o_cpu_done = done_cpu_ff;
   assign o_bus_done = done_bus_ff;

   // read data is the sram output flop itself; each side only trusts it with its done
   assign o_cpu_rdata = mem_rdata;
   assign o_bus_rdata = mem_rdata;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_backup_supply_pin_sram_en <= 1'b1;
      end else begin
         o_backup_supply_pin_sram_en <= !i_backup_retain_off; // R8
      end
   end

   a_lone_cpu_served: assert property (@(posedge i_clk) disable iff (i_reset) // R3
      (i_cpu_req && !i_bus_req) |=> o_cpu_done && !o_bus_done)
      else $error("lone cpu request not served next cycle");

   a_lone_bus_served: assert property (@(posedge i_clk) disable iff (i_reset) // R6
      (i_bus_req && !i_cpu_req) |=> o_bus_done && !o_cpu_done)
      else $error("lone bus request not served next cycle");

   a_contend_alternate: assert property (@(posedge i_clk) disable iff (i_reset) // R4
      (i_cpu_req && i_bus_req) ##1 (i_cpu_req && i_bus_req) |=> (o_cpu_done != $past(o_cpu_done)))
      else $error("contention did not alternate");

   a_contend_one_each: assert property (@(posedge i_clk) disable iff (i_reset) // R7
      (i_cpu_req && i_bus_req) |=> (o_cpu_done ^ o_bus_done))
      else $error("contention served both or neither");

   a_idle_park: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      (!i_cpu_req && !i_bus_req) |=> $stable(o_cpu_gnt) && $stable(o_bus_gnt))
      else $error("grant moved while idle");

   a_single_cycle: assert property (@(posedge i_clk) disable iff (i_reset) // R2
      (o_cpu_gnt && i_cpu_req && !i_bus_req) |=> o_cpu_done ##1 1'b1)
      else $error("granted cpu access took more than one cycle");

   a_reset_park: assert property (@(posedge i_clk) // R9
      $fell(i_reset) |-> o_cpu_gnt && !o_bus_gnt)
      else $error("grant not parked on cpu after reset");

   a_backup_ctrl: assert property (@(posedge i_clk) disable iff (i_reset) // R8
      i_backup_retain_off |=> !o_backup_supply_pin_sram_en)
      else $error("backup switchover not disabled");

   // grant and done checks below lean on gnt showing the owner of the current cycle
   a_backup_ctrl_on: assert property (@(posedge i_clk) disable iff (i_reset) // R8
      !i_backup_retain_off |=> o_backup_supply_pin_sram_en)
      else $error("backup switchover not enabled");

   a_grant_onehot: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      o_cpu_gnt != o_bus_gnt)
      else $error("grant not held by exactly one port");

   a_done_exclusive: assert property (@(posedge i_clk) disable iff (i_reset) // R4
      !(o_cpu_done && o_bus_done))
      else $error("both ports served in one cycle");

   a_contend_bus_wins: assert property (@(posedge i_clk) disable iff (i_reset) // R4
      (i_cpu_req && i_bus_req && o_cpu_gnt) |=> o_bus_done)
      else $error("bus not served when cpu held the memory");

   a_contend_cpu_wins: assert property (@(posedge i_clk) disable iff (i_reset) // R4
      (i_cpu_req && i_bus_req && o_bus_gnt) |=> o_cpu_done)
      else $error("cpu not served when bus held the memory");

   a_contend_gnt_moves: assert property (@(posedge i_clk) disable iff (i_reset) // R4
      (i_cpu_req && i_bus_req) |=> (o_cpu_gnt != $past(o_cpu_gnt)))
      else $error("grant did not move under contention");

   a_bus_park: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      (o_bus_gnt && !i_cpu_req && !i_bus_req) |=> o_bus_gnt)
      else $error("idle grant left the bus");

   a_cpu_park: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      (o_cpu_gnt && !i_cpu_req && !i_bus_req) |=> o_cpu_gnt)
      else $error("idle grant left the cpu");

   a_bus_zero_wait: assert property (@(posedge i_clk) disable iff (i_reset) // R6
      (o_bus_gnt && i_bus_req && !i_cpu_req) |=> o_bus_done)
      else $error("granted bus access took more than one cycle");

   a_cpu_no_req: assert property (@(posedge i_clk) disable iff (i_reset) // R2
      !i_cpu_req |=> !o_cpu_done)
      else $error("cpu done without a request");

   a_bus_no_req: assert property (@(posedge i_clk) disable iff (i_reset) // R7
      !i_bus_req |=> !o_bus_done)
      else $error("bus done without a request");

   a_gnt_after_cpu: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      o_cpu_done |-> o_cpu_gnt)
      else $error("served cpu does not hold the grant");

   a_gnt_after_bus: assert property (@(posedge i_clk) disable iff (i_reset) // R5
      o_bus_done |-> o_bus_gnt)
      else $error("served bus does not hold the grant");
endmodule

// >>> logic/ssa_cfg.svh
// constants for the shared sram port arbiter
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH
`define SSA_WORD_W        32
`define SSA_SIZE_SMALL_KB 64
`define SSA_SIZE_LARGE_KB 96
`define SSA_BYTES_PER_KB  1024
`define SSA_BYTES_PER_WD  4
`endif

// >>> logic/ssa_pkg.sv
// types for the shared sram port arbiter
package ssa_pkg;
   typedef enum logic [1:0] {
      SSA_OWN_CPU = 2'b01,
      SSA_OWN_BUS = 2'b10
   } ssa_owner_t;
endpackage

// >>> logic/ssa_sram.sv
// single-port word-wide sram held in flip-flops
`timescale 1ns/1ps
module ssa_sram #(
   parameter int WORD_W = 32,
   parameter int DEPTH  = 16384,
   parameter int ADDR_W = $clog2(DEPTH)
) (
   input  wire logic              i_clk,
   input  wire logic              i_en,
   input  wire logic              i_we,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [WORD_W-1:0] i_wdata,
   output logic      [WORD_W-1:0] o_rdata
);
   logic [WORD_W-1:0] mem_ff [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_en && i_we) begin
         mem_ff[i_addr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_en && !i_we) begin
         o_rdata <= mem_ff[i_addr];
      end
   end
endmodule
